// ---- inc/alms_pkg.sv ----
package alms_pkg;
   // Number of alarm instances in the block.
   localparam int unsigned NUM_ALARMS = 32;
   // Longest message text, in characters.
   localparam int unsigned MSG_CHARS = 160;
   // Greatest number of embedded operand values over all instances.
   localparam int unsigned MAX_OPERANDS = 128;
   // Most send attempts made for one accepted trigger.
   localparam logic [1:0] MAX_ATTEMPTS = 2'h3;
   // Character that opens and closes an embedded operand name.
   localparam logic [7:0] OPERAND_DELIM = 8'h24;

   // Register byte offsets.
   localparam logic [7:0] OFF_ENABLE = 8'h00;
   localparam logic [7:0] OFF_TRIGGER = 8'h04;
   localparam logic [7:0] OFF_EVAL = 8'h08;
   localparam logic [7:0] OFF_BUSY = 8'h0C;
   localparam logic [7:0] OFF_FAIL = 8'h10;
   localparam logic [7:0] OFF_ECHO = 8'h14;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
   localparam logic [7:0] OFF_SEND_REQ = 8'h20;
   localparam logic [7:0] OFF_SEND_RES = 8'h24;

   // Reset values.
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [31:0] RST_EVAL = 32'hFFFF_FFFF;

   // Bus answers.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Send-result register fields.
   localparam int unsigned RES_DONE_BIT = 0;
   localparam int unsigned RES_OK_BIT = 1;
   localparam int unsigned RES_IDX_LSB = 8;

   typedef enum logic [3:0] {
      ALMS_IDLE = 4'b0001,
      ALMS_SEND = 4'b0010,
      ALMS_WAIT = 4'b0100,
      ALMS_DONE = 4'b1000
   } alms_state_t;
endpackage : alms_pkg

// ---- inc/alms_job_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Per-instance job signals between the controller and one alarm sender.
interface alms_job_if;
   logic enable;
   logic eval_enable;
   logic trigger;
   logic attempt_done;
   logic attempt_ok;
   logic attempt_req;
   logic busy;
   logic failed;
   logic echo;
   logic job_failed_pulse;
   logic job_ok_pulse;
   modport ctrl (
      output enable, eval_enable, trigger, attempt_done, attempt_ok,
      input attempt_req, busy, failed, echo, job_failed_pulse, job_ok_pulse
   );
   modport sender (
      input enable, eval_enable, trigger, attempt_done, attempt_ok,
      output attempt_req, busy, failed, echo, job_failed_pulse, job_ok_pulse
   );
endinterface : alms_job_if
`default_nettype wire

// ---- src/alms_sender.sv ----
`timescale 1ns/100ps
`default_nettype none
module alms_sender (
   input wire logic mclk_in,
   input wire logic resetn_in,
   alms_job_if.sender job
);
   alms_pkg::alms_state_t state_reg;
   logic trig_prev_reg;
   logic [1:0] attempts_reg;
   logic active;
   logic edge_seen;

   assign active = job.enable | ~job.eval_enable;
   assign edge_seen = job.trigger & ~trig_prev_reg;

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         trig_prev_reg <= 1'b0;
      end else begin
         trig_prev_reg <= job.trigger;
      end
   end

   // ************************************************************
   // Job sequence
   // ************************************************************
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         state_reg <= alms_pkg::ALMS_IDLE;
         attempts_reg <= 2'h0;
         job.attempt_req <= 1'b0;
         job.job_failed_pulse <= 1'b0;
         job.job_ok_pulse <= 1'b0;
      end else begin
         job.job_failed_pulse <= 1'b0;
         job.job_ok_pulse <= 1'b0;
         job.attempt_req <= 1'b0;
         case (state_reg)
            alms_pkg::ALMS_IDLE: begin
               // Edges while busy are dropped, never queued.
               if (edge_seen && active) begin
                  attempts_reg <= 2'h0;
                  state_reg <= alms_pkg::ALMS_SEND;
               end
            end
            alms_pkg::ALMS_SEND: begin
               job.attempt_req <= 1'b1;
               attempts_reg <= attempts_reg + 2'h1;
               state_reg <= alms_pkg::ALMS_WAIT;
            end
            alms_pkg::ALMS_WAIT: begin
               // Enable is not looked at here, so dropping it never aborts a job.
               if (job.attempt_done) begin
                  if (job.attempt_ok) begin
                     job.job_ok_pulse <= 1'b1;
                     state_reg <= alms_pkg::ALMS_DONE;
                  end else if (attempts_reg == alms_pkg::MAX_ATTEMPTS) begin
                     job.job_failed_pulse <= 1'b1;
                     state_reg <= alms_pkg::ALMS_DONE;
                  end else begin
                     state_reg <= alms_pkg::ALMS_SEND;
                  end
               end
            end
            alms_pkg::ALMS_DONE: begin
               state_reg <= alms_pkg::ALMS_IDLE;
            end
            default: begin
               state_reg <= alms_pkg::ALMS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         job.busy <= 1'b0;
      end else begin
         job.busy <= (state_reg == alms_pkg::ALMS_SEND) ||
                     (state_reg == alms_pkg::ALMS_WAIT);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         job.failed <= 1'b0;
      end else if (job.job_failed_pulse) begin
         job.failed <= 1'b1;
      end else if (job.job_ok_pulse || (job.eval_enable && !job.enable)) begin
         job.failed <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         job.echo <= 1'b0;
      end else begin
         job.echo <= job.enable;
      end
   end

   sequence s_fail_done;
      job.job_failed_pulse ##1 job.failed;
   endsequence

   property p_fail_sets;
      @(posedge mclk_in) disable iff (!resetn_in)
      job.job_failed_pulse |-> ##1 job.failed;
   endproperty
   a_fail_sets: assert property (p_fail_sets) else $error("fail flag not set");

   property p_ok_clears;
      @(posedge mclk_in) disable iff (!resetn_in)
      job.job_ok_pulse |=> !job.failed;
   endproperty
   a_ok_clears: assert property (p_ok_clears) else $error("fail flag kept after success");

   property p_echo;
      @(posedge mclk_in) disable iff (!resetn_in)
      ##1 job.echo == $past(job.enable);
   endproperty
   a_echo: assert property (p_echo) else $error("echo mismatch");

   property p_no_accept_busy;
      @(posedge mclk_in) disable iff (!resetn_in)
      (state_reg != alms_pkg::ALMS_IDLE) |=> (state_reg != alms_pkg::ALMS_SEND) ||
         $past(state_reg == alms_pkg::ALMS_WAIT);
   endproperty
   a_no_accept_busy: assert property (p_no_accept_busy) else $error("job restarted");

   // A fourth attempt would wrap the two-bit counter back to zero.
   property p_attempt_cap;
      @(posedge mclk_in) disable iff (!resetn_in)
      job.attempt_req |-> attempts_reg != 2'h0;
   endproperty
   a_attempt_cap: assert property (p_attempt_cap) else $error("too many attempts");

   property p_accept;
      @(posedge mclk_in) disable iff (!resetn_in)
      (state_reg == alms_pkg::ALMS_IDLE && edge_seen && active) |-> ##2 job.busy;
   endproperty
   a_accept: assert property (p_accept) else $error("busy not raised");

   property p_busy_drop;
      @(posedge mclk_in) disable iff (!resetn_in)
      (state_reg == alms_pkg::ALMS_DONE) |=> !job.busy;
   endproperty
   a_busy_drop: assert property (p_busy_drop) else $error("busy stuck");

   property p_disabled_ignored;
      @(posedge mclk_in) disable iff (!resetn_in)
      (state_reg == alms_pkg::ALMS_IDLE && job.eval_enable && !job.enable)
         |=> state_reg == alms_pkg::ALMS_IDLE;
   endproperty
   a_disabled_ignored: assert property (p_disabled_ignored) else $error("ran disabled");

   property p_fail_seq;
      @(posedge mclk_in) disable iff (!resetn_in)
      job.job_failed_pulse |-> s_fail_done;
   endproperty
   a_fail_seq: assert property (p_fail_seq) else $error("fail sequence broken");
endmodule : alms_sender
`default_nettype wire

// ---- src/alms_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module alms_top #(
   parameter int unsigned NUM_ALARMS = alms_pkg::NUM_ALARMS,
   parameter int unsigned MSG_CHARS = alms_pkg::MSG_CHARS,
   parameter int unsigned OPERAND_COUNT = 0
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq_out
);
   // Operand budget is a build-time limit over all instances.
   if (OPERAND_COUNT > alms_pkg::MAX_OPERANDS) begin : g_budget
      $error("too many embedded operands");
   end

   // ************************************************************
   // Register state
   // ************************************************************
   logic [31:0] enable_reg;
   logic [31:0] trigger_reg;
   logic [31:0] eval_reg;
   logic [31:0] irq_stat_reg;
   logic [31:0] irq_mask_reg;
   logic [31:0] send_req_reg;
   logic [31:0] busy_vec;
   logic [31:0] fail_vec;
   logic [31:0] echo_vec;
   logic [31:0] req_vec;
   logic [31:0] ok_vec;
   logic [31:0] bad_vec;
   logic [31:0] res_done;
   logic [31:0] res_ok;
   logic [31:0] irq_set;
   logic [31:0] stat_clr;
   logic [7:0] aw_addr_reg;
   logic aw_full_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic w_full_reg;
   logic do_write;
   logic [31:0] res_wdata;

   // Message text per instance, operands written as $name$; only
   // filled with spaces at reset, and nothing here reads it or substitutes operands.
   logic [7:0] msg_mem [NUM_ALARMS][MSG_CHARS];

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic is_delim(input logic [7:0] ch);
      return ch == alms_pkg::OPERAND_DELIM;
   endfunction : is_delim

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         for (int a = 0; a < NUM_ALARMS; a++) begin
            for (int c = 0; c < MSG_CHARS; c++) begin
               msg_mem[a][c] <= 8'h20;
            end
         end
      end
   end

   // ************************************************************
   // Instances
   // ************************************************************
   for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_alarm
      alms_job_if job ();
      assign job.enable = enable_reg[g];
      assign job.eval_enable = eval_reg[g];
      assign job.trigger = trigger_reg[g];
      assign job.attempt_done = res_done[g];
      assign job.attempt_ok = res_ok[g];
      assign busy_vec[g] = job.busy;
      assign fail_vec[g] = job.failed;
      assign echo_vec[g] = job.echo;
      assign req_vec[g] = job.attempt_req;
      assign ok_vec[g] = job.job_ok_pulse;
      assign bad_vec[g] = job.job_failed_pulse;
      alms_sender u_sender (
         .mclk_in(mclk_in),
         .resetn_in(resetn_in),
         .job(job)
      );
   end

   // ************************************************************
   // AXI4-Lite write channel
   // ************************************************************
   assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
   assign res_wdata = merge(32'h0000_0000, w_data_reg, w_strb_reg);

   always_comb begin
      res_done = 32'h0000_0000;
      res_ok = 32'h0000_0000;
      stat_clr = 32'h0000_0000;
      if (do_write && aw_addr_reg == alms_pkg::OFF_SEND_RES) begin
         res_done[res_wdata[alms_pkg::RES_IDX_LSB +: 5]] = res_wdata[alms_pkg::RES_DONE_BIT];
         res_ok[res_wdata[alms_pkg::RES_IDX_LSB +: 5]] = res_wdata[alms_pkg::RES_OK_BIT];
      end
      if (do_write && aw_addr_reg == alms_pkg::OFF_IRQ_STAT) begin
         stat_clr = res_wdata;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_full_reg && !s_axi_awready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
         end else if (do_write) begin
            aw_full_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         w_full_reg <= 1'b0;
         w_data_reg <= alms_pkg::RST_WORD;
         w_strb_reg <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_full_reg && !s_axi_wready;
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (do_write) begin
            w_full_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= alms_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         case (aw_addr_reg)
            alms_pkg::OFF_ENABLE, alms_pkg::OFF_TRIGGER, alms_pkg::OFF_EVAL,
            alms_pkg::OFF_IRQ_STAT, alms_pkg::OFF_IRQ_MASK, alms_pkg::OFF_SEND_RES: begin
               s_axi_bresp <= alms_pkg::RESP_OKAY;
            end
            default: begin
               s_axi_bresp <= alms_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         enable_reg <= alms_pkg::RST_WORD;
         trigger_reg <= alms_pkg::RST_WORD;
         eval_reg <= alms_pkg::RST_EVAL;
         irq_mask_reg <= alms_pkg::RST_WORD;
      end else if (do_write) begin
         case (aw_addr_reg)
            alms_pkg::OFF_ENABLE: enable_reg <= merge(enable_reg, w_data_reg, w_strb_reg);
            alms_pkg::OFF_TRIGGER: trigger_reg <= merge(trigger_reg, w_data_reg, w_strb_reg);
            alms_pkg::OFF_EVAL: eval_reg <= merge(eval_reg, w_data_reg, w_strb_reg);
            alms_pkg::OFF_IRQ_MASK: irq_mask_reg <= merge(irq_mask_reg, w_data_reg, w_strb_reg);
            default: begin
            end
         endcase
      end
   end

   // ************************************************************
   // Transmit requests and interrupts
   // ************************************************************
   // Pending attempt requests; a new request wins over a clear.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         send_req_reg <= alms_pkg::RST_WORD;
      end else begin
         send_req_reg <= (send_req_reg & ~res_done) | req_vec;
      end
   end

   // Events: job ended well in the low half, job failed in the high half
   // would need 64 bits, so both outcomes share one bit per instance.
   assign irq_set = ok_vec | bad_vec;

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         irq_stat_reg <= alms_pkg::RST_WORD;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~stat_clr) | irq_set;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // ************************************************************
   // AXI4-Lite read channel
   // ************************************************************
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= alms_pkg::RST_WORD;
         s_axi_rresp <= alms_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= alms_pkg::RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
               alms_pkg::OFF_ENABLE: s_axi_rdata <= enable_reg;
               alms_pkg::OFF_TRIGGER: s_axi_rdata <= trigger_reg;
               alms_pkg::OFF_EVAL: s_axi_rdata <= eval_reg;
               alms_pkg::OFF_BUSY: s_axi_rdata <= busy_vec;
               alms_pkg::OFF_FAIL: s_axi_rdata <= fail_vec;
               alms_pkg::OFF_ECHO: s_axi_rdata <= echo_vec;
               alms_pkg::OFF_IRQ_STAT: s_axi_rdata <= irq_stat_reg;
               alms_pkg::OFF_IRQ_MASK: s_axi_rdata <= irq_mask_reg;
               alms_pkg::OFF_SEND_REQ: s_axi_rdata <= send_req_reg;
               default: begin
                  s_axi_rdata <= alms_pkg::RST_WORD;
                  s_axi_rresp <= alms_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   property p_irq_level;
      @(posedge mclk_in) disable iff (!resetn_in)
      |(irq_stat_reg & irq_mask_reg) |=> irq_out;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt missing");

   property p_event_sticky;
      @(posedge mclk_in) disable iff (!resetn_in)
      |irq_set |=> |irq_stat_reg;
   endproperty
   a_event_sticky: assert property (p_event_sticky) else $error("event lost");

   property p_delim_known;
      @(posedge mclk_in) disable iff (!resetn_in)
      is_delim(alms_pkg::OPERAND_DELIM);
   endproperty
   a_delim_known: assert property (p_delim_known) else $error("delimiter wrong");

   // ************************************************************
   // Bus and interrupt checks
   // ************************************************************
   property p_irq_quiet;
      @(posedge mclk_in) disable iff (!resetn_in)
      !(|(irq_stat_reg & irq_mask_reg)) |=> !irq_out;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without cause");

   // A status bit may only fall through a write of one to it.
   property p_stat_kept;
      @(posedge mclk_in) disable iff (!resetn_in)
      (stat_clr == 32'h0000_0000) |=>
         ((irq_stat_reg & $past(irq_stat_reg)) == $past(irq_stat_reg));
   endproperty
   a_stat_kept: assert property (p_stat_kept) else $error("status bit lost");

   property p_req_set;
      @(posedge mclk_in) disable iff (!resetn_in)
      |req_vec |=> ((send_req_reg & $past(req_vec)) == $past(req_vec));
   endproperty
   a_req_set: assert property (p_req_set) else $error("attempt request lost");

   property p_write_answer;
      @(posedge mclk_in) disable iff (!resetn_in)
      do_write |=> s_axi_bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("write not answered");

   property p_bvalid_hold;
      @(posedge mclk_in) disable iff (!resetn_in)
      (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp));
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped");

   property p_rvalid_hold;
      @(posedge mclk_in) disable iff (!resetn_in)
      (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata));
   endproperty
   a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer dropped");
endmodule : alms_top
`default_nettype wire

// ---- verification/alms_mail_srv.sv ----
`timescale 1ns/100ps
`default_nettype none
module alms_mail_srv;
   // A scripted outage: the server refuses attempts until it has refused fail_left of them.
   int fail_left = 0;
   int tries = 0;
   task automatic attempt(output logic ok);
      tries++;
      ok = (fail_left == 0) ? 1'b1 : 1'b0;
      if (fail_left > 0) fail_left--;
   endtask : attempt
endmodule : alms_mail_srv
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
$display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
   logic mclk_in = 1'b0, resetn_in = 1'b0, irq_out;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, v, w;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [4:0] g;
   int err_total = 0, num_checks = 0, cycles = 0, k;
   alms_top uut (.mclk_in, .resetn_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_out);
   alms_mail_srv srv ();
   always #10 mclk_in = ~mclk_in;
   // ****************
   // Bus master tasks
   // ****************
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge mclk_in);
      s_axi_awaddr <= {24'h00_0000, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk_in);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk_in);
      s_axi_araddr <= {24'h00_0000, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk_in);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   function automatic int exp_tries(input int nf);
      return (nf >= int'(alms_pkg::MAX_ATTEMPTS)) ? int'(alms_pkg::MAX_ATTEMPTS) : nf + 1;
   endfunction : exp_tries
   // The mail link is played by the bench through the request and result registers.
   task automatic run_job(input logic [4:0] j, input int nf, input bit drop);
      logic [31:0] q;
      logic ok;
      int n;
      srv.fail_left = nf;
      srv.tries = 0;
      wr(alms_pkg::OFF_TRIGGER, 32'h0000_0001 << j, rsp);
      for (n = 0; n < 300; n++) begin
         rd(alms_pkg::OFF_SEND_REQ, q, rsp);
         if (q[j]) begin
            if (srv.tries == 0) begin
               rd(alms_pkg::OFF_BUSY, q, rsp);
               `CHK("busy", 1'b1, q[j])
               wr(alms_pkg::OFF_TRIGGER, 32'h0000_0000, rsp);
               wr(alms_pkg::OFF_TRIGGER, 32'h0000_0001 << j, rsp);
               if (drop) wr(alms_pkg::OFF_ENABLE, 32'h0000_0000, rsp);
            end
            srv.attempt(ok);
            wr(alms_pkg::OFF_SEND_RES, {16'h0000, 3'h0, j, 6'h00, ok, 1'b1}, rsp);
         end else begin
            rd(alms_pkg::OFF_BUSY, q, rsp);
            if (!q[j] && srv.tries > 0) break;
         end
      end
      `CHK("attempts", exp_tries(nf), srv.tries)
      rd(alms_pkg::OFF_BUSY, q, rsp);
      `CHK("busy end", 1'b0, q[j])
      rd(alms_pkg::OFF_FAIL, q, rsp);
      `CHK("fail", (nf >= 3) ? 1'b1 : 1'b0, q[j])
      wr(alms_pkg::OFF_TRIGGER, 32'h0000_0000, rsp);
   endtask : run_job
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         give_verdict();
      end
   end
   // **************
   // Main sequence
   // **************
   initial begin
      void'($urandom(47));
      repeat (6) @(posedge mclk_in);
      resetn_in <= 1'b1;
      rd(alms_pkg::OFF_EVAL, v, rsp);
      `CHK("eval reset", alms_pkg::RST_EVAL, v)
      rd(alms_pkg::OFF_BUSY, v, rsp);
      `CHK("busy reset", alms_pkg::RST_WORD, v)
      rd(8'h3C, v, rsp);
      `CHK("unmapped", {alms_pkg::RESP_SLVERR, 32'h0000_0000}, {rsp, v})
      wr(alms_pkg::OFF_BUSY, 32'hFFFF_FFFF, rsp);
      `CHK("ro write", alms_pkg::RESP_SLVERR, rsp)
      v = $urandom;
      wr(alms_pkg::OFF_ENABLE, v, rsp);
      rd(alms_pkg::OFF_ECHO, w, rsp);
      `CHK("echo", v, w)
      g = 5'($urandom_range(31, 0));
      wr(alms_pkg::OFF_ENABLE, 32'h0000_0001 << g, rsp);
      wr(alms_pkg::OFF_IRQ_MASK, 32'h0000_0000, rsp);
      run_job(g, 0, 1'b0);
      rd(alms_pkg::OFF_IRQ_STAT, v, rsp);
      `CHK("irq stat", 1'b1, v[g])
      `CHK("irq masked", 1'b0, irq_out)
      wr(alms_pkg::OFF_IRQ_MASK, 32'h0000_0001 << g, rsp);
      rd(alms_pkg::OFF_IRQ_STAT, v, rsp);
      `CHK("irq on", 1'b1, irq_out)
      wr(alms_pkg::OFF_IRQ_STAT, 32'h0000_0001 << g, rsp);
      rd(alms_pkg::OFF_IRQ_STAT, v, rsp);
      `CHK("irq clear", 1'b0, irq_out)
      run_job(g, 3, 1'b0);
      wr(alms_pkg::OFF_ENABLE, 32'h0000_0000, rsp);
      rd(alms_pkg::OFF_FAIL, v, rsp);
      `CHK("fail by enable", 1'b0, v[g])
      wr(alms_pkg::OFF_ENABLE, 32'h0000_0001 << g, rsp);
      run_job(g, 3, 1'b0);
      run_job(g, 1, 1'b1);
      for (k = 0; k < 4; k++) begin
         g = 5'($urandom_range(31, 0));
         wr(alms_pkg::OFF_ENABLE, 32'h0000_0001 << g, rsp);
         run_job(g, int'($urandom_range(4, 0)), 1'b0);
      end
      wr(alms_pkg::OFF_ENABLE, 32'h0000_0000, rsp);
      wr(alms_pkg::OFF_EVAL, ~(32'h0000_0001 << g), rsp);
      run_job(g, 0, 1'b0);
      wr(alms_pkg::OFF_EVAL, 32'hFFFF_FFFF, rsp);
      wr(alms_pkg::OFF_TRIGGER, 32'h0000_0001 << g, rsp);
      repeat (10) @(posedge mclk_in);
      rd(alms_pkg::OFF_BUSY, v, rsp);
      `CHK("disabled busy", 1'b0, v[g])
      rd(alms_pkg::OFF_SEND_REQ, v, rsp);
      `CHK("disabled req", 1'b0, v[g])
      wr(alms_pkg::OFF_TRIGGER, 32'h0000_0000, rsp);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
